// File: cmg_regs.sv
/*
 * codec mixer input gain, record select/gain and misc control bank.
 * assumes the serial link slot decoder delivers one-cycle write and
 * read strobes with a 7-bit offset, on SYS_CLK, and that reads are
 * answered with registered data one cycle later.
 */
`timescale 1ns/10ps
module cmg_regs (
    input  wire logic        SYS_CLK,
    input  wire logic        RST_N,
    input  wire logic        CLK_EN,
    input  wire logic        WR_STB,
    input  wire logic        RD_STB,
    input  wire logic [6:0]  REG_ADDR,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        EXT_MODE,
    output logic [15:0]      RD_DATA,
    output logic             RD_VALID,
    output logic [4:0]       PHONE_ATTEN,
    output logic             PHONE_MUTE_L,
    output logic             PHONE_MUTE_R,
    output logic [4:0]       MIC_ATTEN,
    output logic             MIC_BOOST,
    output logic             MIC_MUTE,
    output logic [4:0]       LINE_LEFT_ATTEN,
    output logic [4:0]       LINE_RIGHT_ATTEN,
    output logic             LINE_MUTE,
    output logic [4:0]       DISC_LEFT_ATTEN,
    output logic [4:0]       DISC_RIGHT_ATTEN,
    output logic             DISC_MUTE,
    output logic [4:0]       PLAYBACK_LEFT_ATTEN,
    output logic [4:0]       PLAYBACK_RIGHT_ATTEN,
    output logic             PLAYBACK_MUTE,
    output logic [2:0]       RECORD_LEFT_SOURCE,
    output logic [2:0]       RECORD_RIGHT_SOURCE,
    output logic [3:0]       RECORD_LEFT_GAIN,
    output logic [3:0]       RECORD_RIGHT_GAIN,
    output logic             RECORD_MUTE,
    output logic             MONO_MIX_SOURCE_SELECT,
    output logic             ADC_TO_DAC_LOOPBACK
);
    cmg_bus_if bus ();
    logic [15:0] bank_r [cmg_pkg::NREG];
    logic [15:0] rd_data_r;
    logic        rd_valid_r;
    logic        soft_reset;

    // reset value and write mask per index
    function automatic logic [15:0] rst_val(input logic [2:0] i);
        unique case (i)
            cmg_pkg::IX_PHONE:   rst_val = cmg_pkg::RST_PHONE;
            cmg_pkg::IX_MIC:     rst_val = cmg_pkg::RST_MIC;
            cmg_pkg::IX_LINE:    rst_val = cmg_pkg::RST_LINE;
            cmg_pkg::IX_CD:      rst_val = cmg_pkg::RST_CD;
            cmg_pkg::IX_PCM:     rst_val = cmg_pkg::RST_PCM;
            cmg_pkg::IX_RECSEL:  rst_val = cmg_pkg::RST_RECSEL;
            cmg_pkg::IX_RECGAIN: rst_val = cmg_pkg::RST_RECGAIN;
            cmg_pkg::IX_MISC:    rst_val = cmg_pkg::RST_MISC;
        endcase
    endfunction

    function automatic logic [15:0] wr_mask(input logic [2:0] i);
        unique case (i)
            cmg_pkg::IX_PHONE:   wr_mask = cmg_pkg::MSK_PHONE;
            cmg_pkg::IX_MIC:     wr_mask = cmg_pkg::MSK_MIC;
            cmg_pkg::IX_LINE,
            cmg_pkg::IX_CD,
            cmg_pkg::IX_PCM:     wr_mask = cmg_pkg::MSK_STEREO;
            cmg_pkg::IX_RECSEL:  wr_mask = cmg_pkg::MSK_RECSEL;
            cmg_pkg::IX_RECGAIN: wr_mask = cmg_pkg::MSK_RECGAIN;
            cmg_pkg::IX_MISC:    wr_mask = cmg_pkg::MSK_MISC;
        endcase
    endfunction

    // offset decoding
    assign bus.addr = REG_ADDR;
    cmg_decode u_decode (
        .bus (bus)
    );

    assign soft_reset = WR_STB && bus.is_reset;

    // register bank, one word per generate slot
    for (genvar g = 0; g < cmg_pkg::NREG; g++) begin : g_bank
        localparam logic [2:0] IX = 3'(g);
        always_ff @(posedge SYS_CLK) begin
            if (!RST_N) begin
                bank_r[g] <= rst_val(IX);
            end else if (CLK_EN) begin
                if (soft_reset) begin
                    bank_r[g] <= rst_val(IX);
                end else if (WR_STB && bus.hit && bus.idx == IX) begin
                    bank_r[g] <= WR_DATA & wr_mask(IX);
                end
            end
        end
    end

    // read data, one cycle after the strobe
    always_ff @(posedge SYS_CLK) begin
        if (!RST_N) begin
            rd_data_r  <= 16'h0000;
            rd_valid_r <= 1'b0;
        end else if (CLK_EN) begin
            rd_valid_r <= RD_STB;
            if (RD_STB) begin
                rd_data_r <= bus.hit ? bank_r[bus.idx] : 16'h0000;
            end
        end
    end
    assign RD_DATA  = rd_data_r;
    assign RD_VALID = rd_valid_r;

    // analog control fields; codes pass straight to the gain stages, except PHONE_MUTE_R, which EXT_MODE forces low
    assign PHONE_ATTEN  = bank_r[cmg_pkg::IX_PHONE][4:0];
    assign PHONE_MUTE_L = bank_r[cmg_pkg::IX_PHONE][cmg_pkg::MUTE_BIT];
    assign PHONE_MUTE_R = bank_r[cmg_pkg::IX_PHONE][cmg_pkg::MUTE_BIT]
                          && !EXT_MODE;
    assign MIC_ATTEN    = bank_r[cmg_pkg::IX_MIC][4:0];
    assign MIC_BOOST    = bank_r[cmg_pkg::IX_MIC][cmg_pkg::BOOST_BIT];
    assign MIC_MUTE     = bank_r[cmg_pkg::IX_MIC][cmg_pkg::MUTE_BIT];
    assign LINE_LEFT_ATTEN  = bank_r[cmg_pkg::IX_LINE][12:8];
    assign LINE_RIGHT_ATTEN = bank_r[cmg_pkg::IX_LINE][4:0];
    assign LINE_MUTE        = bank_r[cmg_pkg::IX_LINE][cmg_pkg::MUTE_BIT];
    assign DISC_LEFT_ATTEN  = bank_r[cmg_pkg::IX_CD][12:8];
    assign DISC_RIGHT_ATTEN = bank_r[cmg_pkg::IX_CD][4:0];
    assign DISC_MUTE        = bank_r[cmg_pkg::IX_CD][cmg_pkg::MUTE_BIT];
    assign PLAYBACK_LEFT_ATTEN  = bank_r[cmg_pkg::IX_PCM][12:8];
    assign PLAYBACK_RIGHT_ATTEN = bank_r[cmg_pkg::IX_PCM][4:0];
    assign PLAYBACK_MUTE = bank_r[cmg_pkg::IX_PCM][cmg_pkg::MUTE_BIT];
    assign RECORD_LEFT_SOURCE  = bank_r[cmg_pkg::IX_RECSEL][10:8];
    assign RECORD_RIGHT_SOURCE = bank_r[cmg_pkg::IX_RECSEL][2:0];
    assign RECORD_LEFT_GAIN  = bank_r[cmg_pkg::IX_RECGAIN][11:8];
    assign RECORD_RIGHT_GAIN = bank_r[cmg_pkg::IX_RECGAIN][3:0];
    assign RECORD_MUTE = bank_r[cmg_pkg::IX_RECGAIN][cmg_pkg::MUTE_BIT];
    assign MONO_MIX_SOURCE_SELECT =
        bank_r[cmg_pkg::IX_MISC][cmg_pkg::MONO_SEL_BIT];
    assign ADC_TO_DAC_LOOPBACK = bank_r[cmg_pkg::IX_MISC][cmg_pkg::LOOP_BIT];

    // checks
    sequence s_reset_write;
        WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_RESET;
    endsequence

    property p_soft_reset;
        @(posedge SYS_CLK) disable iff (!RST_N)
        s_reset_write |=> bank_r[cmg_pkg::IX_LINE] == cmg_pkg::RST_LINE
            && bank_r[cmg_pkg::IX_RECGAIN] == cmg_pkg::RST_RECGAIN
            && bank_r[cmg_pkg::IX_MISC] == cmg_pkg::RST_MISC;
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("reset register write did not restore defaults");

    property p_phone_mute_ext;
        @(posedge SYS_CLK) disable iff (!RST_N)
        EXT_MODE |-> !PHONE_MUTE_R;
    endproperty
    a_phone_mute_ext: assert property (p_phone_mute_ext)
        else $error("phone right muted in extended mode");

    property p_mute_follows;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_CD)
            |=> DISC_MUTE == $past(WR_DATA[15]);
    endproperty
    a_mute_follows: assert property (p_mute_follows)
        else $error("cd mute not taken from bit 15");

    property p_line_fields;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_LINE)
            |=> LINE_LEFT_ATTEN == $past(WR_DATA[12:8])
             && LINE_RIGHT_ATTEN == $past(WR_DATA[4:0]);
    endproperty
    a_line_fields: assert property (p_line_fields)
        else $error("line gain fields wrong");

    property p_pcm_fields;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_PCM)
            |=> PLAYBACK_LEFT_ATTEN == $past(WR_DATA[12:8])
             && PLAYBACK_RIGHT_ATTEN == $past(WR_DATA[4:0]);
    endproperty
    a_pcm_fields: assert property (p_pcm_fields)
        else $error("pcm gain fields wrong");

    property p_recsel;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_RECSEL)
            |=> RECORD_LEFT_SOURCE == $past(WR_DATA[10:8])
             && RECORD_RIGHT_SOURCE == $past(WR_DATA[2:0]);
    endproperty
    a_recsel: assert property (p_recsel)
        else $error("record source fields wrong");

    property p_recgain;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_RECGAIN)
            |=> RECORD_LEFT_GAIN == $past(WR_DATA[11:8])
             && RECORD_RIGHT_GAIN == $past(WR_DATA[3:0]);
    endproperty
    a_recgain: assert property (p_recgain)
        else $error("record gain fields wrong");

    property p_misc;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_MISC)
            |=> ADC_TO_DAC_LOOPBACK == $past(WR_DATA[7])
             && MONO_MIX_SOURCE_SELECT == $past(WR_DATA[9]);
    endproperty
    a_misc: assert property (p_misc)
        else $error("misc control bits wrong");

    property p_dont_care_zero;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (RD_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_MIC)
            |=> (RD_DATA & ~cmg_pkg::MSK_MIC) == 16'h0000 && RD_VALID;
    endproperty
    a_dont_care_zero: assert property (p_dont_care_zero)
        else $error("don't-care bits read nonzero");

    property p_mic_boost;
        @(posedge SYS_CLK) disable iff (!RST_N)
        (WR_STB && CLK_EN && REG_ADDR == cmg_pkg::OFS_MIC)
            |=> MIC_BOOST == $past(WR_DATA[6]) && MIC_ATTEN == $past(WR_DATA[4:0]);
    endproperty
    a_mic_boost: assert property (p_mic_boost)
        else $error("mic fields wrong");
endmodule // cmg_regs

// File: cmg_pkg.sv
/*
 * package for the codec mixer gain register bank: offsets, field
 * positions, reset values and enumerations.
 * assumes nothing of its surroundings.
 */
package cmg_pkg;
    localparam logic [6:0] OFS_RESET      = 7'h00;
    localparam logic [6:0] OFS_PHONE      = 7'h0c;
    localparam logic [6:0] OFS_MIC        = 7'h0e;
    localparam logic [6:0] OFS_LINE       = 7'h10;
    localparam logic [6:0] OFS_CD         = 7'h12;
    localparam logic [6:0] OFS_PCM        = 7'h18;
    localparam logic [6:0] OFS_RECSEL     = 7'h1a;
    localparam logic [6:0] OFS_RECGAIN    = 7'h1c;
    localparam logic [6:0] OFS_MISC       = 7'h20;

    localparam logic [15:0] RST_PHONE     = 16'h8008;
    localparam logic [15:0] RST_MIC       = 16'h8008;
    localparam logic [15:0] RST_LINE      = 16'h8808;
    localparam logic [15:0] RST_CD        = 16'h8808;
    localparam logic [15:0] RST_PCM       = 16'h8808;
    localparam logic [15:0] RST_RECSEL    = 16'h0000;
    localparam logic [15:0] RST_RECGAIN   = 16'h8000;
    localparam logic [15:0] RST_MISC      = 16'h0000;

    // writable bit masks; all other bits ignored and read as zero
    localparam logic [15:0] MSK_PHONE     = 16'h801f;
    localparam logic [15:0] MSK_MIC       = 16'h805f;
    localparam logic [15:0] MSK_STEREO    = 16'h9f1f;
    localparam logic [15:0] MSK_RECSEL    = 16'h0707;
    localparam logic [15:0] MSK_RECGAIN   = 16'h8f0f;
    localparam logic [15:0] MSK_MISC      = 16'h0280;

    localparam int MUTE_BIT    = 15;
    localparam int BOOST_BIT   = 6;
    localparam int MONO_SEL_BIT = 9;
    localparam int LOOP_BIT    = 7;
    localparam int LEFT_LSB    = 8;

    // index of each register in the bank
    localparam int NREG        = 8;
    localparam logic [2:0] IX_PHONE   = 3'h0;
    localparam logic [2:0] IX_MIC     = 3'h1;
    localparam logic [2:0] IX_LINE    = 3'h2;
    localparam logic [2:0] IX_CD      = 3'h3;
    localparam logic [2:0] IX_PCM     = 3'h4;
    localparam logic [2:0] IX_RECSEL  = 3'h5;
    localparam logic [2:0] IX_RECGAIN = 3'h6;
    localparam logic [2:0] IX_MISC    = 3'h7;

    typedef enum logic [2:0] {
        CMG_SRC_MIC      = 3'b000,
        CMG_SRC_CD       = 3'b001,
        CMG_SRC_MONO_MIX = 3'b010,
        CMG_SRC_PRE_OUT  = 3'b011,
        CMG_SRC_LINE     = 3'b100,
        CMG_SRC_STEREO_NOPCM = 3'b101,
        CMG_SRC_MONO_NOPCM   = 3'b110,
        CMG_SRC_PHONE    = 3'b111
    } cmg_src_t;
endpackage

// File: cmg_bus_if.sv
/*
 * interface carrying one decoded register access between the top
 * and the address decoder.
 * assumes a single clock domain.
 */
`timescale 1ns/10ps
interface cmg_bus_if;
    logic [6:0] addr;
    logic       hit;
    logic [2:0] idx;
    logic       is_reset;
    modport dec (input addr, output hit, output idx, output is_reset);
    modport top (output addr, input hit, input idx, input is_reset);
endinterface

// File: cmg_decode.sv
/*
 * address decoder for the mixer gain register bank.
 * assumes word offsets as printed; odd offsets never hit.
 */
`timescale 1ns/10ps
module cmg_decode (
    cmg_bus_if.dec bus
);
    // offset to bank index
    always_comb begin
        bus.hit      = 1'b1;
        bus.idx      = cmg_pkg::IX_PHONE;
        bus.is_reset = (bus.addr == cmg_pkg::OFS_RESET);
        unique case (bus.addr)
            cmg_pkg::OFS_PHONE:   bus.idx = cmg_pkg::IX_PHONE;
            cmg_pkg::OFS_MIC:     bus.idx = cmg_pkg::IX_MIC;
            cmg_pkg::OFS_LINE:    bus.idx = cmg_pkg::IX_LINE;
            cmg_pkg::OFS_CD:      bus.idx = cmg_pkg::IX_CD;
            cmg_pkg::OFS_PCM:     bus.idx = cmg_pkg::IX_PCM;
            cmg_pkg::OFS_RECSEL:  bus.idx = cmg_pkg::IX_RECSEL;
            cmg_pkg::OFS_RECGAIN: bus.idx = cmg_pkg::IX_RECGAIN;
            cmg_pkg::OFS_MISC:    bus.idx = cmg_pkg::IX_MISC;
            default:              bus.hit = 1'b0;
        endcase
    end
endmodule // cmg_decode

// File: cmg_ctrl_model.sv
/*
 * controller model: issues one-cycle register write and read strobes.
 * assumes the bank answers a read with a one-cycle valid pulse.
 */
`timescale 1ns/10ps
module cmg_ctrl_model (
    input  wire logic        clk,
    input  wire logic        rd_valid,
    input  wire logic [15:0] rd_data,
    output logic             clk_en,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [6:0]       reg_addr,
    output logic [15:0]      wr_data
);
    // idle values at time zero
    initial begin
        {clk_en, wr_stb, rd_stb, reg_addr, wr_data} = {1'b1, 1'b0, 1'b0, 7'h55, 16'ha5a5};
    end

    // write: strobe one cycle, then show the inverse of the last value
    task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic en);
        @(posedge clk);
        #1;
        {clk_en, wr_stb, reg_addr, wr_data} = {en, 1'b1, a, d};
        @(posedge clk);
        #1;
        {clk_en, wr_stb, reg_addr, wr_data} = {1'b1, 1'b0, ~a, ~d};
    endtask

    // read: strobe one cycle, then a bounded wait for the answer
    task automatic rd(input logic [6:0] a, output logic [15:0] d, output bit ok);
        int n;
        @(posedge clk);
        #1;
        {rd_stb, reg_addr} = {1'b1, a};
        @(posedge clk);
        #1;
        {rd_stb, reg_addr} = {1'b0, ~a};
        ok = 1'b0;
        d = 16'h0000;
        for (n = 0; n < 4 && !ok; n++) begin
            if (rd_valid === 1'b1) begin
                ok = 1'b1;
                d = rd_data;
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask

    // change only chosen bits: read first, then write back
    task automatic rmw(input logic [6:0] a, input logic [15:0] set, clr, output bit ok);
        logic [15:0] v;
        rd(a, v, ok);
        wr(a, (v & ~clr) | set, 1'b1);
    endtask
endmodule // cmg_ctrl_model

// File: codec_mixer_gain_registers_bench.sv
/*
 * self-checking bench for the mixer gain register bank.
 * assumes the controller model drives strobes just after the clock edge.
 */
`timescale 1ns/10ps
module codec_mixer_gain_registers_bench;
    logic        sys_clk, rst_n, ext_mode, clk_en, wr_stb, rd_stb, rd_valid;
    logic [6:0]  reg_addr;
    logic [15:0] wr_data, rd_data, got;
    logic [4:0]  ph_at, mic_at, li_l, li_r, cd_l, cd_r, pb_l, pb_r;
    logic        ph_ml, ph_mr, mic_bo, mic_mu, li_mu, cd_mu, pb_mu, rec_mu, mono_sel, loop_en;
    logic [2:0]  src_l, src_r;
    logic [3:0]  rg_l, rg_r;
    int          num_errors, checks_done, i, k;
    bit          ok;
    logic [15:0] m [8];
    localparam logic [6:0] ADR [8] = '{cmg_pkg::OFS_PHONE, cmg_pkg::OFS_MIC, cmg_pkg::OFS_LINE,
        cmg_pkg::OFS_CD, cmg_pkg::OFS_PCM, cmg_pkg::OFS_RECSEL, cmg_pkg::OFS_RECGAIN,
        cmg_pkg::OFS_MISC};
    localparam logic [15:0] DEF [8] = '{cmg_pkg::RST_PHONE, cmg_pkg::RST_MIC, cmg_pkg::RST_LINE,
        cmg_pkg::RST_CD, cmg_pkg::RST_PCM, cmg_pkg::RST_RECSEL, cmg_pkg::RST_RECGAIN,
        cmg_pkg::RST_MISC};
    localparam logic [15:0] MSK [8] = '{16'h801f, 16'h805f, 16'h9f1f, 16'h9f1f, 16'h9f1f,
        16'h0707, 16'h8f0f, 16'h0280};
    localparam logic [6:0] BAD [5] = '{7'h02, 7'h0d, 7'h14, 7'h22, 7'h7f};

    // 50 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    cmg_regs DUT (.SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .WR_STB(wr_stb),
        .RD_STB(rd_stb), .REG_ADDR(reg_addr), .WR_DATA(wr_data), .EXT_MODE(ext_mode),
        .RD_DATA(rd_data), .RD_VALID(rd_valid), .PHONE_ATTEN(ph_at), .PHONE_MUTE_L(ph_ml),
        .PHONE_MUTE_R(ph_mr), .MIC_ATTEN(mic_at), .MIC_BOOST(mic_bo), .MIC_MUTE(mic_mu),
        .LINE_LEFT_ATTEN(li_l), .LINE_RIGHT_ATTEN(li_r), .LINE_MUTE(li_mu),
        .DISC_LEFT_ATTEN(cd_l), .DISC_RIGHT_ATTEN(cd_r), .DISC_MUTE(cd_mu),
        .PLAYBACK_LEFT_ATTEN(pb_l), .PLAYBACK_RIGHT_ATTEN(pb_r), .PLAYBACK_MUTE(pb_mu),
        .RECORD_LEFT_SOURCE(src_l), .RECORD_RIGHT_SOURCE(src_r), .RECORD_LEFT_GAIN(rg_l),
        .RECORD_RIGHT_GAIN(rg_r), .RECORD_MUTE(rec_mu), .MONO_MIX_SOURCE_SELECT(mono_sel),
        .ADC_TO_DAC_LOOPBACK(loop_en));

    cmg_ctrl_model ctrl (.clk(sys_clk), .rd_valid(rd_valid), .rd_data(rd_data),
        .clk_en(clk_en), .wr_stb(wr_stb), .rd_stb(rd_stb), .reg_addr(reg_addr),
        .wr_data(wr_data));

    // verdict and end of run
    task automatic final_report;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // compare read data
    task automatic chk_rd(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t read got %h exp %h", $time, g, e);
        end
    endtask

    // compare a group of control outputs
    task automatic chk_out(input logic [15:0] g, e);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("[ERR] %0t outputs got %h exp %h", $time, g, e);
        end
    endtask

    // all control outputs against the model bank
    task automatic check_outs;
        chk_out({ph_ml, ph_mr, 9'h0, ph_at}, {m[0][15], m[0][15] & ~ext_mode, 9'h0, m[0][4:0]});
        chk_out({mic_mu, 9'h0, mic_bo, mic_at}, {m[1][15], 9'h0, m[1][6], m[1][4:0]});
        chk_out({li_mu, 2'h0, li_l, 3'h0, li_r}, m[2]);
        chk_out({cd_mu, 2'h0, cd_l, 3'h0, cd_r}, m[3]);
        chk_out({pb_mu, 2'h0, pb_l, 3'h0, pb_r}, m[4]);
        chk_out({5'h0, src_l, 5'h0, src_r}, m[5]);
        chk_out({rec_mu, 3'h0, rg_l, 4'h0, rg_r}, m[6]);
        chk_out({6'h0, mono_sel, 1'h0, loop_en, 7'h0}, m[7]);
    endtask

    // write through the model and update the expected bank
    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        int j;
        for (j = 0; j < 8; j++)
            if (ADR[j] == a)
                m[j] = d & MSK[j];
        if (a == cmg_pkg::OFS_RESET)
            m = DEF;
        ctrl.wr(a, d, 1'b1);
        check_outs();
    endtask

    // read-modify-write of misc through the model; a lost answer counts an error and ends the run
    task automatic rmw(input logic [15:0] set, clr);
        ctrl.rmw(cmg_pkg::OFS_MISC, set, clr, ok);
        if (!ok) begin
            num_errors++;
            $display("[ERR] %0t no read answer in read-modify-write", $time);
            final_report();
        end
        m[7] = ((m[7] & ~clr) | set) & MSK[7];
        check_outs();
    endtask

    // read through the model; unmapped places read zero
    task automatic rd(input logic [6:0] a);
        int j;
        logic [15:0] e;
        e = 16'h0000;
        for (j = 0; j < 8; j++)
            if (ADR[j] == a)
                e = m[j];
        ctrl.rd(a, got, ok);
        if (!ok) begin
            num_errors++;
            $display("[ERR] %0t no read answer", $time);
            final_report();
        end
        chk_rd(got, e);
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        final_report();
    end

    // main sequence
    initial begin
        {num_errors, checks_done, ext_mode, rst_n} = '0;
        m = DEF;
        void'($urandom(32'hc78a));
        repeat (10) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        for (i = 0; i < 8; i++) rd(ADR[i]);
        check_outs();
        $display("test defaults done");
        repeat (4) for (i = 0; i < 8; i++) wr(ADR[i], 16'($urandom));
        for (i = 0; i < 8; i++) rd(ADR[i]);
        $display("test random writes done");
        for (k = 0; k < 8; k++) wr(cmg_pkg::OFS_RECSEL, {5'h1f, 3'(k), 5'h1f, 3'(7 - k)});
        rd(cmg_pkg::OFS_RECSEL);
        $display("test record sources done");
        wr(cmg_pkg::OFS_PHONE, 16'h801f);
        ext_mode = 1'b1;
        repeat (2) @(posedge sys_clk);
        #1;
        check_outs();
        wr(cmg_pkg::OFS_PHONE, 16'($urandom));
        wr(cmg_pkg::OFS_PHONE, 16'h8000);
        ext_mode = 1'b0;
        @(posedge sys_clk);
        #1;
        check_outs();
        $display("test extended mode done");
        for (i = 0; i < 5; i++) begin
            wr(BAD[i], 16'($urandom));
            rd(BAD[i]);
        end
        $display("test unmapped done");
        rmw(16'h0080, 16'h0200);
        rmw(16'h0200, 16'h0000);
        rd(cmg_pkg::OFS_MISC);
        ctrl.wr(cmg_pkg::OFS_LINE, 16'h0000, 1'b0);
        check_outs();
        $display("test misc and clock enable done");
        wr(cmg_pkg::OFS_RESET, 16'($urandom));
        for (i = 0; i < 8; i++) rd(ADR[i]);
        wr(cmg_pkg::OFS_CD, 16'h1234);
        rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rst_n = 1'b1;
        m = DEF;
        check_outs();
        $display("test resets done");
        final_report();
    end
endmodule // codec_mixer_gain_registers_bench
